// ### hdl/cdd_decoder.sv
// Class-of-device word decoder with register port and serial input.
// Assumes one 10 MHz clock, synchronous inputs, bus master per house rules.
//
// What this block does
// (R1) Take a 32-bit class word, split into service, major and minor fields.
// (R2) Format type starts at bit 0; pair 11 means the field extends.
// (R3) Apply first layout only for format 00; flag others unsupported.
// (R4) Eleven service bits are an independent mask, any may be set.
// (R5) Supplier drives reserved and unassigned bits to zero.
// (R6) Serial words travel bit 0 first, ascending.
// (R7) Service bit 13 is limited discoverable; bits 14 and 15 reserved.
// (R8) Service bits 16 to 23: positioning through information, in order.
// (R9) Major class is the five bits 12 down to 8.
// (R10) Major codes 0 to 6: misc, computer, phone, AP, A/V, periph, imaging.
// (R11) All-ones major is uncategorized; other unlisted codes flagged reserved.
// (R12) Minor field is bits 7 to 2, read only against the major class.
// (R13) Computer minors 0 to 6 decoded; others reserved.
// (R14) Phone minors 0 to 6 decoded; others reserved.
// (R15) Supplier encodes only the primary minor class.
// (R16) Outputs registered one clock after a valid word; reset clears them.
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ps
`include "cdd_defines.svh"

module cdd_decoder
    import cdd_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic COD_VALID,
    input wire logic [31:0] COD_WORD,
    input wire logic SER_BIT,
    input wire logic SER_STB,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    output cdd_dec_t DEC_OUT,
    output logic IRQ
);

    ////////////////////////////////////////////////////////////////////////
    // Pure decode of one word

    function automatic cdd_dec_t decode(input logic [31:0] w);
        cdd_dec_t d;
        logic [4:0] maj;
        logic [5:0] mnr;
        d = '0;
        maj = w[`CDD_MAJOR_MSB:`CDD_MAJOR_LSB]; // R9
        mnr = w[`CDD_MINOR_MSB:`CDD_MINOR_LSB]; // R12
        d.vld = 1'b1;
        d.fmt = w[`CDD_FMT_MSB:`CDD_FMT_LSB]; // R2
        d.fmt_ext = (d.fmt == `CDD_FMT_EXTEND); // R2
        d.fmt_unsup = (d.fmt != `CDD_FMT_FIRST); // R3
        // Other formats keep only the format flags
        if (!d.fmt_unsup) begin
            d.lim_disc = w[`CDD_LIMDISC_BIT]; // R7
            d.svc_rsvd = w[`CDD_SVCRSV_MSB:`CDD_SVCRSV_LSB]; // R7
            d.svc_cat = w[`CDD_SVCCAT_MSB:`CDD_SVCCAT_LSB]; // R4 R8
            d.major = maj;
            d.minor = mnr;
            d.bits_rsvd = (|d.svc_rsvd) | (|w[`CDD_TOP_MSB:`CDD_TOP_LSB]); // R5
            case (maj)
                CDD_MAJ_MISC: d.major_oh = 8'h01; // R10
                CDD_MAJ_COMPUTER: d.major_oh = 8'h02;
                CDD_MAJ_PHONE: d.major_oh = 8'h04;
                CDD_MAJ_NETAP: d.major_oh = 8'h08;
                CDD_MAJ_AUDIOVIDEO: d.major_oh = 8'h10;
                CDD_MAJ_PERIPH: d.major_oh = 8'h20;
                CDD_MAJ_IMAGING: d.major_oh = 8'h40;
                CDD_MAJ_UNCAT: d.major_oh = 8'h80; // R11
                default: d.major_rsvd = 1'b1; // R11
            endcase
            // Minors of other majors are passed raw, not judged
            if (maj == CDD_MAJ_COMPUTER || maj == CDD_MAJ_PHONE) begin
                if (mnr < 6'd7) begin
                    d.minor_oh = 7'(7'h01 << mnr[2:0]); // R13 R14
                end else begin
                    d.minor_rsvd = 1'b1; // R13 R14
                end
            end
        end
        return d;
    endfunction : decode

    ////////////////////////////////////////////////////////////////////////
    // Next state

    cdd_state_t s_q;
    cdd_state_t s_d;

    always_comb begin
        logic take;
        logic [31:0] w;
        logic [`CDD_EV_N-1:0] ev;
        logic [`CDD_EV_N-1:0] clr;
        s_d = s_q;
        take = 1'b0;
        w = s_q.word;
        ev = '0;
        clr = '0;
        s_d.dec.vld = 1'b0;
        s_d.rdata = 32'h0000_0000;
        // Serial shift, LSB first into the top
        if (SER_STB) begin
            s_d.sh = {SER_BIT, s_q.sh[31:1]}; // R6
            s_d.cnt = 5'(s_q.cnt + 5'd1);
        end
        // Parallel port wins over bus, bus over serial completion
        if (COD_VALID) begin
            take = 1'b1;
            w = COD_WORD; // R1
        end else if (WR && ADDR == `CDD_ADDR_WORD) begin
            take = 1'b1;
            w = WDATA;
        end else if (SER_STB && s_q.cnt == `CDD_LAST_SER_CNT) begin
            take = 1'b1;
            w = {SER_BIT, s_q.sh[31:1]}; // R6
        end
        if (take) begin
            s_d.word = w;
            s_d.dec = decode(w); // R16
            ev[`CDD_EV_DONE] = 1'b1;
            ev[`CDD_EV_FMT] = s_d.dec.fmt_unsup;
            ev[`CDD_EV_MAJOR] = s_d.dec.major_rsvd;
            ev[`CDD_EV_MINOR] = s_d.dec.minor_rsvd;
            ev[`CDD_EV_RSVBITS] = s_d.dec.bits_rsvd;
        end
        if (WR) begin
            case (ADDR)
                `CDD_ADDR_STATUS: clr = WDATA[`CDD_EV_N-1:0];
                `CDD_ADDR_MASK: s_d.mask = WDATA[`CDD_EV_N-1:0];
                `CDD_ADDR_SERCNT: s_d.cnt = 5'd0;
                default: clr = '0;
            endcase
        end
        // Set beats clear so no event is lost
        s_d.sts = (s_q.sts & ~clr) | ev;
        s_d.irq = |(s_d.sts & s_d.mask);
        if (RD) begin
            case (ADDR)
                `CDD_ADDR_WORD: s_d.rdata = s_q.word;
                `CDD_ADDR_STATUS: s_d.rdata = 32'(s_q.sts);
                `CDD_ADDR_MASK: s_d.rdata = 32'(s_q.mask);
                `CDD_ADDR_RESULT: s_d.rdata = {s_q.dec.svc_cat, 2'b00,
                    s_q.dec.bits_rsvd, s_q.dec.minor_rsvd, s_q.dec.major_rsvd,
                    s_q.dec.fmt_unsup, s_q.dec.lim_disc, s_q.dec.fmt_ext,
                    2'b00, s_q.dec.minor, 3'b000, s_q.dec.major};
                `CDD_ADDR_SERCNT: s_d.rdata = 32'(s_q.cnt);
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_q <= '0; // R16
        end else begin
            s_q <= s_d;
        end
    end

    assign RDATA = s_q.rdata;
    assign DEC_OUT = s_q.dec;
    assign IRQ = s_q.irq;

endmodule : cdd_decoder

// ### hdl/cdd_defines.svh
// Offsets, field positions and reset values of the class word decoder.
// Included by the package and the decoder; defines only.
`ifndef CDD_DEFINES_SVH
`define CDD_DEFINES_SVH

// Register byte addresses
`define CDD_ADDR_WORD 8'h00
`define CDD_ADDR_STATUS 8'h04
`define CDD_ADDR_MASK 8'h08
`define CDD_ADDR_RESULT 8'h0C
`define CDD_ADDR_SERCNT 8'h10

// Class word field positions
`define CDD_FMT_MSB 1
`define CDD_FMT_LSB 0
`define CDD_MINOR_MSB 7
`define CDD_MINOR_LSB 2
`define CDD_MAJOR_MSB 12
`define CDD_MAJOR_LSB 8
`define CDD_LIMDISC_BIT 13
`define CDD_SVCRSV_MSB 15
`define CDD_SVCRSV_LSB 14
`define CDD_SVCCAT_MSB 23
`define CDD_SVCCAT_LSB 16
`define CDD_TOP_MSB 31
`define CDD_TOP_LSB 24

// Format codes
`define CDD_FMT_FIRST 2'h0
`define CDD_FMT_EXTEND 2'h3

// Status and mask bit positions
`define CDD_EV_DONE 0
`define CDD_EV_FMT 1
`define CDD_EV_MAJOR 2
`define CDD_EV_MINOR 3
`define CDD_EV_RSVBITS 4
`define CDD_EV_N 5

// Reset values and the serial count of the last bit
`define CDD_WORD_RST 32'h0000_0000
`define CDD_MASK_RST 5'h00
`define CDD_LAST_SER_CNT 5'h1F

`endif

// ### hdl/cdd_pkg.sv
// Types shared by the class word decoder and its bench.
// Assumes cdd_defines.svh is on the include path.
`include "cdd_defines.svh"

package cdd_pkg;

    typedef enum logic [4:0] {
        CDD_MAJ_MISC = 5'h00,
        CDD_MAJ_COMPUTER = 5'h01,
        CDD_MAJ_PHONE = 5'h02,
        CDD_MAJ_NETAP = 5'h03,
        CDD_MAJ_AUDIOVIDEO = 5'h04,
        CDD_MAJ_PERIPH = 5'h05,
        CDD_MAJ_IMAGING = 5'h06,
        CDD_MAJ_UNCAT = 5'h1F
    } cdd_major_t;

    // One-hot major: [0] misc .. [6] imaging, [7] uncategorized
    // One-hot minor: [0] uncategorized .. [6] wearable / card reader
    typedef struct packed {
        logic vld;
        logic [1:0] fmt;
        logic fmt_unsup;
        logic fmt_ext;
        logic lim_disc;
        logic [1:0] svc_rsvd;
        logic [7:0] svc_cat;
        logic [4:0] major;
        logic [7:0] major_oh;
        logic major_rsvd;
        logic [5:0] minor;
        logic [6:0] minor_oh;
        logic minor_rsvd;
        logic bits_rsvd;
    } cdd_dec_t;

    typedef struct packed {
        cdd_dec_t dec;
        logic [31:0] word;
        logic [`CDD_EV_N-1:0] sts;
        logic [`CDD_EV_N-1:0] mask;
        logic irq;
        logic [31:0] rdata;
        logic [31:0] sh;
        logic [4:0] cnt;
    } cdd_state_t;

endpackage : cdd_pkg

// ### verif/cdd_assertions.sv
// Port checker for cdd_decoder.
// Bound below; one clock, async low reset.
`timescale 1ns/1ps
module cdd_assertions
    import cdd_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic COD_VALID,
    input wire logic [31:0] COD_WORD,
    input wire cdd_dec_t DEC_OUT
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence s_take; COD_VALID && COD_WORD[1:0] == 2'h0; endsequence
    property p_vld; COD_VALID |=> DEC_OUT.vld; endproperty
    a_vld: assert property (p_vld) else $error("vld");
    property p_fmt;
        COD_VALID |=> DEC_OUT.fmt_unsup == ($past(COD_WORD[1:0]) != 2'h0);
    endproperty
    a_fmt: assert property (p_fmt) else $error("fmt");
    property p_ext;
        COD_VALID |=> DEC_OUT.fmt_ext == ($past(COD_WORD[1:0]) == 2'h3);
    endproperty
    a_ext: assert property (p_ext) else $error("ext");
    property p_maj; s_take |=> DEC_OUT.major == $past(COD_WORD[12:8]); endproperty
    a_maj: assert property (p_maj) else $error("maj");
    property p_svc; s_take |=> DEC_OUT.svc_cat == $past(COD_WORD[23:16]); endproperty
    a_svc: assert property (p_svc) else $error("svc");
    property p_lim; s_take |=> DEC_OUT.lim_disc == $past(COD_WORD[13]); endproperty
    a_lim: assert property (p_lim) else $error("lim");
    property p_min; s_take |=> DEC_OUT.minor == $past(COD_WORD[7:2]); endproperty
    a_min: assert property (p_min) else $error("min");
    property p_unc;
        s_take |=> DEC_OUT.major_oh[7] == ($past(COD_WORD[12:8]) == 5'h1F);
    endproperty
    a_unc: assert property (p_unc) else $error("unc");
    property p_rsv; s_take |=> DEC_OUT.svc_rsvd == $past(COD_WORD[15:14]); endproperty
    a_rsv: assert property (p_rsv) else $error("rsv");
    property p_fld; COD_VALID |=> DEC_OUT.fmt == $past(COD_WORD[1:0]); endproperty
    a_fld: assert property (p_fld) else $error("fld");
endmodule : cdd_assertions
////////////////////////////////////////
bind cdd_decoder cdd_assertions cdd_assertions_inst (.CLK(CLK), .RST_N(RST_N),
    .COD_VALID(COD_VALID), .COD_WORD(COD_WORD), .DEC_OUT(DEC_OUT));

// ### verif/cdd_host_model.sv
// Host side: sends class words serially.
// Bench calls send; clock from the bench.
`timescale 1ns/1ps
module cdd_host_model (
    input wire logic clk,
    output logic ser_bit,
    output logic ser_stb
);
    initial begin
        ser_bit = 1'h0;
        ser_stb = 1'h0;
    end
    // Idle data shows the inverse, never a stale bit
    task automatic send(input logic [31:0] w, input int gap);
        logic [31:0] c;
        c = w & 32'h00FF_3FFF;
        for (int i = 0; i < 32; i++) begin
            repeat (gap) begin
                @(posedge clk);
                ser_stb <= 1'h0;
                ser_bit <= ~c[i];
            end
            @(posedge clk);
            ser_stb <= 1'h1;
            ser_bit <= c[i];
        end
        @(posedge clk);
        ser_stb <= 1'h0;
        ser_bit <= ~c[31];
    endtask : send
endmodule : cdd_host_model

// ### verif/testbench.sv
// Bench for cdd_decoder: words, registers, serial.
// Host model drives serial pins; checker bound.
`timescale 1ns/1ps
module testbench;
    logic CLK = '0, RST_N = '0, COD_VALID = '0, WR = '0, RD = '0;
    logic SER_BIT, SER_STB, IRQ;
    logic [31:0] COD_WORD = '0, WDATA = '0, RDATA;
    logic [7:0] ADDR = '0;
    cdd_pkg::cdd_dec_t DEC_OUT;
    int mismatches = 0, checks = 0;
    logic [59:0] tv [9];
    always #50 CLK = ~CLK;
    cdd_decoder cdd_decoder_inst (.CLK(CLK), .RST_N(RST_N), .COD_VALID(COD_VALID),
        .COD_WORD(COD_WORD), .SER_BIT(SER_BIT), .SER_STB(SER_STB), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .DEC_OUT(DEC_OUT), .IRQ(IRQ));
    cdd_host_model cdd_host_model_inst (.clk(CLK), .ser_bit(SER_BIT), .ser_stb(SER_STB));
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude
    task automatic cmp(input logic [59:0] got, input logic [59:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %0t: got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    // Read data only in the cycle after the strobe
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= w;
        RD <= !w;
        @(posedge CLK);
        WR <= 1'h0;
        RD <= 1'h0;
        #1;
        if (!w)
            cmp(60'(RDATA), 60'(d));
    endtask : bus
    function automatic logic [59:0] view();
        return 60'({DEC_OUT.vld, DEC_OUT.fmt_unsup, DEC_OUT.fmt_ext, DEC_OUT.major_rsvd,
            DEC_OUT.minor_rsvd, DEC_OUT.bits_rsvd, DEC_OUT.svc_cat, DEC_OUT.major_oh,
            DEC_OUT.minor_oh});
    endfunction : view
    initial begin
        #200_000;
        mismatches++;
        conclude();
    end
    initial begin
        tv = '{{32'h00A0_210C, 5'h00, 8'hA0, 8'h02, 7'h08},
            {32'h0000_0218, 5'h00, 8'h00, 8'h04, 7'h40},
            {32'h0000_1F00, 5'h00, 8'h00, 8'h80, 7'h00},
            {32'h0000_0700, 5'h04, 8'h00, 8'h00, 7'h00},
            {32'h0000_011C, 5'h02, 8'h00, 8'h02, 7'h00},
            {32'h0000_0101, 5'h10, 8'h00, 8'h00, 7'h00},
            {32'h0000_0103, 5'h18, 8'h00, 8'h00, 7'h00},
            {32'h0000_4100, 5'h01, 8'h00, 8'h02, 7'h01},
            {32'h00FF_0000, 5'h00, 8'hFF, 8'h01, 7'h00}};
        repeat (2) @(posedge CLK);
        cmp(view(), 60'h0);
        RST_N <= 1'h1;
        bus(1'h0, 8'h04, 32'h0000_0000);
        foreach (tv[i]) begin
            @(posedge CLK);
            COD_VALID <= 1'h1;
            COD_WORD <= tv[i][59:28];
            @(posedge CLK);
            COD_VALID <= 1'h0;
            #1;
            cmp(view(), {31'h0, 1'h1, tv[i][27:0]});
        end
        cmp(60'(IRQ), 60'h0);
        bus(1'h0, 8'h04, 32'h0000_001F);
        bus(1'h0, 8'h0C, 32'hFF00_0000);
        bus(1'h0, 8'h40, 32'h0000_0000);
        bus(1'h1, 8'h08, 32'h0000_0004);
        cmp(60'(IRQ), 60'h1);
        bus(1'h1, 8'h04, 32'h0000_0004);
        cmp(60'(IRQ), 60'h0);
        bus(1'h0, 8'h08, 32'h0000_0004);
        cdd_host_model_inst.send(32'hFF44_C204, 1);
        #1;
        cmp(view(), {31'h0, 1'h1, 5'h00, 8'h44, 8'h04, 7'h02});
        bus(1'h0, 8'h10, 32'h0000_0000);
        bus(1'h0, 8'h00, 32'h0044_0204);
        bus(1'h1, 8'h00, 32'h0020_0500);
        #1;
        cmp(view(), {31'h0, 1'h1, 5'h00, 8'h20, 8'h20, 7'h00});
        bus(1'h0, 8'h0C, 32'h2000_0005);
        bus(1'h1, 8'h10, 32'h0000_0000);
        bus(1'h0, 8'h10, 32'h0000_0000);
        conclude();
    end
endmodule : testbench
